// ==== logic/pepmc_top.sv ====
// poll mode controller: configuration, sampling, actions, status
`timescale 1ns/1ps
`default_nettype none
`include "pepmc_cfg.svh"
module pepmc_top #(
    parameter int NPIN = 32,
    parameter int PW = $clog2(NPIN)
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic step_done,
    input wire logic [NPIN-1:0] pin_in,
    input wire logic mode_wr,
    input wire pepmc_pkg::pepmc_mode_t mode_val,
    input wire logic watch_wr,
    input wire logic [PW-1:0] watch_pin,
    input wire logic watch_level,
    input wire logic react_wr,
    input wire logic [PW-1:0] react_pin,
    input wire logic react_level,
    input wire logic slot_wr,
    input wire logic [2:0] slot_val,
    output logic [NPIN-1:0] react_out,
    output logic [NPIN-1:0] react_oe,
    output logic jump_req,
    output logic [2:0] jump_slot,
    output logic wait_event,
    output logic [NPIN-1:0] trig_status,
    output logic [7:0] mode_status,
    output logic [7:0] slot_status,
    output logic [7:0] flags_status
);
    import pepmc_pkg::*;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    pepmc_poll_if #(.NPIN(NPIN)) pl ();

    pepmc_match #(.NPIN(NPIN)) u_match (
        .pl(pl.matcher)
    );

    pepmc_drive #(.NPIN(NPIN)) u_drive (
        .pl(pl.driver)
    );

    logic [NPIN-1:0] watch_mask_ff, nxt_watch_mask;
    logic [NPIN-1:0] watch_level_ff, nxt_watch_level;
    logic [NPIN-1:0] react_mask_ff, nxt_react_mask;
    logic [NPIN-1:0] react_level_ff, nxt_react_level;
    logic [NPIN-1:0] oe_ff, nxt_oe;
    logic [2:0] slot_ff, nxt_slot;

    pepmc_mode_t mode_ff, nxt_mode;
    logic [NPIN-1:0] out_ff;
    logic [NPIN-1:0] trig_ff, nxt_trig;
    logic trig_state_ff, nxt_trig_state;
    logic latched_ff, nxt_latched;
    logic wait_ff, nxt_wait;
    logic jump_pend_ff, nxt_jump_pend;
    logic jump_ff, nxt_jump;
    logic [7:0] flags_ff, nxt_flags;

    pepmc_action_t wr_act;
    pepmc_action_t cur_act;
    logic wr_clear;
    logic active;
    logic out_en;
    logic run_en;
    logic latch_on;
    logic sample;

    assign wr_act = pepmc_action_t'(mode_val[2:0]);
    assign cur_act = pepmc_action_t'(mode_ff[2:0]);
    assign wr_clear = mode_wr && (wr_act == PEPMC_CLRIN ||
        wr_act == PEPMC_CLROUT || wr_act == PEPMC_CLRALL);
    // decode of the mode in force; bit 3 only selects latching
    assign active = cur_act == PEPMC_OUT || cur_act == PEPMC_RUN ||
        cur_act == PEPMC_BOTH;
    assign out_en = cur_act == PEPMC_OUT || cur_act == PEPMC_BOTH;
    assign run_en = cur_act == PEPMC_RUN || cur_act == PEPMC_BOTH;
    assign latch_on = mode_ff[`PEPMC_LATCH_BIT];
    // polling looks only between instructions, never mid-command
    assign sample = step_done && active;

    assign pl.pin_in = pin_in;
    assign pl.watch_mask = watch_mask_ff;
    assign pl.watch_level = watch_level_ff;
    assign pl.react_mask = react_mask_ff;
    assign pl.react_level = react_level_ff;
    assign pl.out_cur = out_ff;
    assign pl.update = sample && out_en;
    assign pl.drive_active = pl.any_hit || nxt_latched;

    always_comb begin
        nxt_watch_mask = watch_mask_ff;
        nxt_watch_level = watch_level_ff;
        nxt_react_mask = react_mask_ff;
        nxt_react_level = react_level_ff;
        nxt_oe = oe_ff;
        nxt_slot = slot_ff;
        // a clear in the same cycle as a define wins
        if (watch_wr) begin
            nxt_watch_mask[watch_pin] = 1'b1;
            nxt_watch_level[watch_pin] = watch_level;
        end
        if (react_wr) begin
            nxt_react_mask[react_pin] = 1'b1;
            nxt_react_level[react_pin] = react_level;
            nxt_oe[react_pin] = 1'b1;
        end
        if (slot_wr) begin
            nxt_slot = slot_val;
        end
        if (mode_wr) begin
            case (wr_act)
                PEPMC_OFF: begin
                    nxt_watch_mask = '0;
                    nxt_watch_level = '0;
                    nxt_react_mask = '0;
                    nxt_react_level = '0;
                    nxt_oe = '0;
                end
                PEPMC_CLRIN: begin
                    nxt_watch_mask = '0;
                    nxt_watch_level = '0;
                end
                PEPMC_CLROUT: begin
                    // pins keep driving their present level
                    nxt_react_mask = '0;
                    nxt_react_level = '0;
                end
                PEPMC_CLRALL: begin
                    nxt_watch_mask = '0;
                    nxt_watch_level = '0;
                    nxt_react_mask = '0;
                    nxt_react_level = '0;
                end
                default: begin
                    // mode 1 and the active modes keep it all
                    nxt_watch_mask = nxt_watch_mask;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            watch_mask_ff <= '0;
            watch_level_ff <= '0;
            react_mask_ff <= '0;
            react_level_ff <= '0;
            oe_ff <= '0;
            slot_ff <= 3'h0;
        end else begin
            watch_mask_ff <= nxt_watch_mask;
            watch_level_ff <= nxt_watch_level;
            react_mask_ff <= nxt_react_mask;
            react_level_ff <= nxt_react_level;
            oe_ff <= nxt_oe;
            slot_ff <= nxt_slot;
        end
    end

    always_comb begin
        nxt_mode = mode_ff;
        nxt_trig = trig_ff;
        nxt_trig_state = trig_state_ff;
        nxt_latched = latched_ff;
        nxt_wait = wait_ff;
        nxt_jump_pend = 1'b0;
        nxt_jump = 1'b0;
        // one cycle after the output update the jump fires
        if (jump_pend_ff) begin
            nxt_jump = 1'b1;
            if (cur_act == PEPMC_RUN) begin
                nxt_mode = {mode_ff[3], `PEPMC_A_SAVE};
            end else if (cur_act == PEPMC_BOTH) begin
                nxt_mode = {mode_ff[3], `PEPMC_A_OUT};
            end
        end
        if (mode_wr && !wr_clear) begin
            nxt_mode = mode_val;
            nxt_trig = '0;
            nxt_trig_state = 1'b0;
            nxt_latched = 1'b0;
        end
        // the wait flag goes away only on a mode command
        if (mode_wr) begin
            nxt_wait = 1'b0;
        end
        if (sample) begin
            nxt_trig = latch_on ? (trig_ff | pl.match) : pl.match;
            nxt_trig_state = pl.any_hit;
            if (out_en && latch_on && pl.any_hit) begin
                nxt_latched = 1'b1;
            end
            if (out_en && pl.any_hit) begin
                nxt_wait = 1'b1;
            end
            // pending guard keeps the one-shot from firing twice
            if (run_en && pl.any_hit && !jump_pend_ff) begin
                nxt_jump_pend = 1'b1;
            end
        end
        nxt_flags = 8'h00;
        nxt_flags[`PEPMC_F_OUTEN] = nxt_mode[2:0] == `PEPMC_A_OUT ||
            nxt_mode[2:0] == `PEPMC_A_BOTH;
        nxt_flags[`PEPMC_F_INDEF] = |nxt_watch_mask;
        nxt_flags[`PEPMC_F_RUNEN] = nxt_mode[2:0] == `PEPMC_A_RUN ||
            nxt_mode[2:0] == `PEPMC_A_BOTH;
        nxt_flags[`PEPMC_F_LATCH] = nxt_mode[`PEPMC_LATCH_BIT];
        nxt_flags[`PEPMC_F_TRIG] = nxt_trig_state;
        nxt_flags[`PEPMC_F_LATCHED] = nxt_latched;
        nxt_flags[`PEPMC_F_WAIT] = nxt_wait;
        nxt_flags[`PEPMC_F_ACTIVE] = nxt_flags[`PEPMC_F_OUTEN] ||
            nxt_flags[`PEPMC_F_RUNEN];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_ff <= `PEPMC_MODE_RST;
            out_ff <= '0;
            trig_ff <= '0;
            trig_state_ff <= 1'b0;
            latched_ff <= 1'b0;
            wait_ff <= 1'b0;
            jump_pend_ff <= 1'b0;
            jump_ff <= 1'b0;
            flags_ff <= 8'h00;
        end else begin
            mode_ff <= nxt_mode;
            out_ff <= pl.out_nxt;
            trig_ff <= nxt_trig;
            trig_state_ff <= nxt_trig_state;
            latched_ff <= nxt_latched;
            wait_ff <= nxt_wait;
            jump_pend_ff <= nxt_jump_pend;
            jump_ff <= nxt_jump;
            flags_ff <= nxt_flags;
        end
    end

    // status is a direct register view, no read side effects
    assign react_out = out_ff;
    assign react_oe = oe_ff;
    assign jump_req = jump_ff;
    assign jump_slot = slot_ff;
    assign wait_event = wait_ff;
    assign trig_status = trig_ff;
    assign mode_status = {4'h0, mode_ff};
    assign slot_status = {5'h0, slot_ff};
    assign flags_status = flags_ff;

    sequence s_run_hit(logic [2:0] act);
        step_done && cur_act == act && pl.any_hit && !jump_pend_ff &&
            !mode_wr;
    endsequence

    sequence s_quiet;
        !mode_wr ##1 1'b1;
    endsequence

    trig_on_step_a: assert property (
        !step_done && !mode_wr |=> trig_ff == $past(trig_ff))
        else $error("trigger flags moved without a step");

    mode_zero_a: assert property (
        mode_wr && mode_val == 4'h0 |=> mode_ff == 4'h0 &&
            watch_mask_ff == '0 && react_mask_ff == '0)
        else $error("mode 0 left configuration behind");

    save_keeps_a: assert property (
        mode_wr && mode_val == 4'h1 && !react_wr && !watch_wr |=>
            react_mask_ff == $past(react_mask_ff) &&
            watch_mask_ff == $past(watch_mask_ff) && !flags_ff[7])
        else $error("mode 1 lost configuration");

    run_oneshot_a: assert property (
        s_run_hit(PEPMC_RUN) ##1 s_quiet |-> jump_req &&
            mode_ff[2:0] == 3'h1)
        else $error("mode 3 jump did not fall back to 1");

    both_oneshot_a: assert property (
        s_run_hit(PEPMC_BOTH) ##1 s_quiet |-> jump_req &&
            mode_ff[2:0] == 3'h2)
        else $error("mode 4 jump did not fall back to 2");

    clear_keeps_mode_a: assert property (
        wr_clear && !jump_pend_ff |=> mode_ff == $past(mode_ff))
        else $error("clearing mode replaced the mode");

    clear_keeps_out_a: assert property (
        wr_clear && !step_done |=> react_out == $past(react_out))
        else $error("clearing mode changed an output level");

    out_then_jump_a: assert property (
        $rose(jump_req) |-> $past(jump_pend_ff) && $past(step_done, 2))
        else $error("jump without a prior sampled update");

    track_level_a: assert property (
        sample && out_en && !latch_on && !latched_ff |=>
            ((react_out ^ $past(react_level_ff)) & $past(react_mask_ff))
            == ($past(pl.any_hit) ? '0 : $past(react_mask_ff)))
        else $error("output does not follow trigger level");

    wait_sticky_a: assert property (
        wait_event && !mode_wr |=> wait_event)
        else $error("wait flag cleared without a mode command");

    no_wait_no_out_a: assert property (
        !wait_event && !(sample && out_en) |=> !wait_event)
        else $error("wait flag set outside an output mode");
endmodule : pepmc_top
`default_nettype wire

// ==== logic/pepmc_cfg.svh ====
// constants for the pin event poll mode controller
// How it works
// - sample watched pins once per finished instruction
// - mode 0 stops polling, clears pin configuration, keeps jump slot
// - mode 1 stops polling, keeps configuration
// - mode 2 runs outputs and wait, no jump
// - mode 3 jumps only, then becomes 1
// - mode 4 does all, then becomes 2
// - modes 5,6,7 clear inputs, outputs, both
// - clearing modes keep the previous mode value
// - clearing modes leave output levels untouched
// - modes 8 to 15 latch outputs once triggered
// - outputs defined later act without new mode
// - mode 1 keeps pins as outputs, idle
// - reactivation resumes with retained configuration
// - unlatched outputs follow watched trigger level
// - output update comes before slot jump
// - status bytes visible to running program
// - mode value in low nibble of status
// - per-pin trigger flags, one means triggered
// - flags byte; wait flag cleared by mode
// - any watched pin triggers all outputs
`ifndef PEPMC_CFG_SVH
`define PEPMC_CFG_SVH
`define PEPMC_MODE_RST 4'h0
`define PEPMC_LATCH_BIT 3
`define PEPMC_A_OFF 3'h0
`define PEPMC_A_SAVE 3'h1
`define PEPMC_A_OUT 3'h2
`define PEPMC_A_RUN 3'h3
`define PEPMC_A_BOTH 3'h4
`define PEPMC_A_CLRIN 3'h5
`define PEPMC_A_CLROUT 3'h6
`define PEPMC_A_CLRALL 3'h7
`define PEPMC_F_OUTEN 0
`define PEPMC_F_INDEF 1
`define PEPMC_F_RUNEN 2
`define PEPMC_F_LATCH 3
`define PEPMC_F_TRIG 4
`define PEPMC_F_LATCHED 5
`define PEPMC_F_WAIT 6
`define PEPMC_F_ACTIVE 7
`endif

// ==== logic/pepmc_pkg.sv ====
// types for the pin event poll mode controller
`include "pepmc_cfg.svh"
package pepmc_pkg;
    typedef logic [3:0] pepmc_mode_t;
    typedef enum logic [2:0] {
        PEPMC_OFF = `PEPMC_A_OFF,
        PEPMC_SAVE = `PEPMC_A_SAVE,
        PEPMC_OUT = `PEPMC_A_OUT,
        PEPMC_RUN = `PEPMC_A_RUN,
        PEPMC_BOTH = `PEPMC_A_BOTH,
        PEPMC_CLRIN = `PEPMC_A_CLRIN,
        PEPMC_CLROUT = `PEPMC_A_CLROUT,
        PEPMC_CLRALL = `PEPMC_A_CLRALL
    } pepmc_action_t;
endpackage : pepmc_pkg

// ==== logic/pepmc_poll_if.sv ====
// carrier between controller, pin matcher and output driver
`timescale 1ns/1ps
`default_nettype none
interface pepmc_poll_if #(parameter int NPIN = 32);
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] watch_mask;
    logic [NPIN-1:0] watch_level;
    logic [NPIN-1:0] match;
    logic any_hit;
    logic [NPIN-1:0] react_mask;
    logic [NPIN-1:0] react_level;
    logic [NPIN-1:0] out_cur;
    logic update;
    logic drive_active;
    logic [NPIN-1:0] out_nxt;
    modport matcher (input pin_in, watch_mask, watch_level,
        output match, any_hit);
    modport driver (input react_mask, react_level, out_cur, update,
        drive_active, output out_nxt);
    modport ctrl (output pin_in, watch_mask, watch_level, react_mask,
        react_level, out_cur, update, drive_active,
        input match, any_hit, out_nxt);
endinterface : pepmc_poll_if
`default_nettype wire

// ==== logic/pepmc_match.sv ====
// per-pin trigger detection on watched inputs
`timescale 1ns/1ps
`default_nettype none
module pepmc_match #(
    parameter int NPIN = 32
) (
    pepmc_poll_if.matcher pl
);
    import pepmc_pkg::*;
    genvar i;
    generate
        for (i = 0; i < NPIN; i++) begin : g_pin
            // only defined pins may report a hit
            assign pl.match[i] = pl.watch_mask[i] &
                ~(pl.pin_in[i] ^ pl.watch_level[i]);
        end
    endgenerate
    // any watched pin fires all outputs
    assign pl.any_hit = |pl.match;
endmodule : pepmc_match
`default_nettype wire

// ==== logic/pepmc_drive.sv ====
// next level of each reacting output pin
`timescale 1ns/1ps
`default_nettype none
module pepmc_drive #(
    parameter int NPIN = 32
) (
    pepmc_poll_if.driver pl
);
    import pepmc_pkg::*;
    genvar i;
    generate
        for (i = 0; i < NPIN; i++) begin : g_pin
            // unconfigured pins hold their level
            assign pl.out_nxt[i] = (pl.update && pl.react_mask[i]) ?
                (pl.drive_active ? pl.react_level[i] :
                ~pl.react_level[i]) : pl.out_cur[i];
        end
    endgenerate
endmodule : pepmc_drive
`default_nettype wire

// ==== verif/pepmc_far.sv ====
// far-side model: watched input pins and interpreter poll points
`timescale 1ns/1ps
`default_nettype none
module pepmc_far (
    input wire logic clock,
    input wire logic jump_req,
    output logic step_done,
    output logic [31:0] pin_in
);
    int n_jump = 0;
    initial begin
        step_done = 1'b0;
        pin_in = 32'hFFFFFFFF;
    end
    task automatic set_pins(input logic [31:0] v);
        @(posedge clock);
        #1 pin_in = v;
    endtask : set_pins
    // poll point only between instructions, one cycle wide
    task automatic poll_point();
        @(posedge clock);
        #1 step_done = 1'b1;
        @(posedge clock);
        #1 step_done = 1'b0;
    endtask : poll_point
    // count jumps taken; a jump is never queued here
    always @(posedge clock) begin
        if (jump_req === 1'b1) begin
            n_jump <= n_jump + 1;
        end
    end
endmodule : pepmc_far
`default_nettype wire

// ==== verif/tb_top.sv ====
// testbench for the poll mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic step_done;
    logic [31:0] pin_in;
    logic mode_wr = 1'b0;
    pepmc_pkg::pepmc_mode_t mode_val = 4'h0;
    logic watch_wr = 1'b0;
    logic [4:0] watch_pin = 5'h00;
    logic watch_level = 1'b0;
    logic react_wr = 1'b0;
    logic [4:0] react_pin = 5'h00;
    logic react_level = 1'b0;
    logic slot_wr = 1'b0;
    logic [2:0] slot_val = 3'h0;
    logic [31:0] react_out, react_oe, trig_status;
    logic jump_req, wait_event;
    logic [2:0] jump_slot;
    logic [7:0] mode_status, slot_status, flags_status;
    int n_mismatch = 0;
    int n_compared = 0;
    localparam logic [31:0] HI = 32'hFFFFFFFF;
    localparam logic [31:0] P0 = 32'hFFFFFFFE;
    localparam logic [31:0] P17 = 32'hFFFDFFFF;

    initial begin
        forever #5 clock = ~clock;
    end

    pepmc_top #(.NPIN(32)) uut (.clock(clock), .rst_n(rst_n),
        .step_done(step_done), .pin_in(pin_in), .mode_wr(mode_wr),
        .mode_val(mode_val), .watch_wr(watch_wr), .watch_pin(watch_pin),
        .watch_level(watch_level), .react_wr(react_wr),
        .react_pin(react_pin), .react_level(react_level),
        .slot_wr(slot_wr), .slot_val(slot_val), .react_out(react_out),
        .react_oe(react_oe), .jump_req(jump_req), .jump_slot(jump_slot),
        .wait_event(wait_event), .trig_status(trig_status),
        .mode_status(mode_status), .slot_status(slot_status),
        .flags_status(flags_status));

    pepmc_far far (.clock(clock), .jump_req(jump_req),
        .step_done(step_done), .pin_in(pin_in));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic cmd_mode(input logic [3:0] v);
        @(posedge clock);
        #1 mode_wr = 1'b1;
        mode_val = v;
        @(posedge clock);
        #1 mode_wr = 1'b0;
    endtask : cmd_mode

    // kind 0 watched pin, 1 reacting pin, 2 jump slot
    task automatic define(input int kind, input logic [4:0] p,
                          input logic l);
        @(posedge clock);
        #1 watch_pin = p;
        react_pin = p;
        slot_val = p[2:0];
        watch_level = l;
        react_level = l;
        watch_wr = (kind == 0);
        react_wr = (kind == 1);
        slot_wr = (kind == 2);
        @(posedge clock);
        #1 watch_wr = 1'b0;
        react_wr = 1'b0;
        slot_wr = 1'b0;
    endtask : define

    // outputs of a sample are settled when this returns
    task automatic poll(input logic [31:0] v);
        far.set_pins(v);
        far.poll_point();
    endtask : poll

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // hang guard: the sequence is far shorter than this
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        final_report();
    end

    initial begin
        tick(10);
        rst_n = 1'b1;
        check({react_out, react_oe}, 64'h0);
        check({mode_status, flags_status, trig_status}, 64'h0);
        check({jump_req, wait_event}, 64'h0);
        $display("test reset done");

        define(0, 5'h00, 1'b0);
        define(0, 5'h11, 1'b0);
        define(1, 5'h01, 1'b1);
        define(1, 5'h02, 1'b0);
        cmd_mode(4'h2);
        check(mode_status, 8'h02);
        tick(1);
        check(flags_status, 8'h83);
        poll(HI);
        check(react_out, 32'h4);
        far.set_pins(P0);
        tick(3);
        check(react_out, 32'h4);
        poll(P0);
        check(react_out, 32'h2);
        check(trig_status[0], 1'b1);
        check(wait_event, 1'b1);
        poll(P17);
        check(react_out, 32'h2);
        check(trig_status[17], 1'b1);
        poll(HI);
        check(react_out, 32'h4);
        check(far.n_jump, 0);
        $display("test output mode done");

        cmd_mode(4'h1);
        check(mode_status, 8'h01);
        check(wait_event, 1'b0);
        poll(P0);
        check(react_out, 32'h4);
        check(react_oe, 32'h6);
        tick(1);
        check(flags_status[7], 1'b0);
        cmd_mode(4'h2);
        poll(P0);
        check(react_out, 32'h2);
        $display("test save and resume done");

        poll(HI);
        define(2, 5'h05, 1'b0);
        cmd_mode(4'h4);
        check(mode_status, 8'h04);
        poll(P0);
        check(react_out, 32'h2);
        check(jump_req, 1'b0);
        tick(1);
        check({jump_req, jump_slot}, {1'b1, 3'h5});
        check(mode_status, 8'h02);
        check(slot_status, 8'h05);
        tick(1);
        check(jump_req, 1'b0);
        poll(HI);
        poll(P0);
        check(react_out, 32'h2);
        check(far.n_jump, 1);
        $display("test jump with outputs done");

        poll(HI);
        cmd_mode(4'h3);
        poll(P0);
        check(react_out, 32'h4);
        tick(1);
        check(jump_req, 1'b1);
        check(mode_status, 8'h01);
        $display("test run only done");

        cmd_mode(4'h2);
        poll(P0);
        cmd_mode(4'h6);
        check(mode_status, 8'h02);
        check(react_out, 32'h2);
        poll(HI);
        check(react_out, 32'h2);
        define(1, 5'h03, 1'b1);
        poll(P0);
        check(react_out, 32'hA);
        cmd_mode(4'h5);
        check(mode_status, 8'h02);
        tick(1);
        check(flags_status[1], 1'b0);
        cmd_mode(4'h7);
        check(mode_status, 8'h02);
        $display("test clearing modes done");

        cmd_mode(4'h0);
        check(mode_status, 8'h00);
        tick(1);
        check({react_oe, flags_status}, 40'h0);
        define(0, 5'h00, 1'b0);
        define(1, 5'h01, 1'b1);
        cmd_mode(4'hA);
        check(mode_status, 8'h0A);
        tick(1);
        check(flags_status[3], 1'b1);
        poll(HI);
        check(react_out[1], 1'b0);
        poll(P0);
        check(react_out[1], 1'b1);
        poll(HI);
        check(react_out[1], 1'b1);
        tick(1);
        check(flags_status[5], 1'b1);
        $display("test latched done");

        cmd_mode(4'hC);
        check(mode_status, 8'h0C);
        poll(P0);
        tick(1);
        check({jump_req, mode_status}, {1'b1, 8'h0A});
        cmd_mode(4'h8);
        check(mode_status, 8'h08);
        check(react_oe, 32'h0);
        $display("test latched jump done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
